// ### pkg/pbs_consts.svh
// Constants for the burst address sequencer: offsets, fields, resets, sizes
`ifndef PBS_CONSTS_SVH
`define PBS_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PBS_CFG_OFS    8'h00
`define PBS_STAT_OFS   8'h04
`define PBS_ADDR_OFS   8'h08
`define PBS_START_OFS  8'h0C

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PBS_HYB_BIT    2
`define PBS_CFG_RST    3'h7
`define PBS_ST_BUSY    0
`define PBS_ST_LIN     1
`define PBS_ST_OVR     2
`define PBS_BT_BIT     45

// ----------------------------------------
// Sizes and counts
// ----------------------------------------
`define PBS_CA_LAST    3'h5
`define PBS_FIFO_W     32
`define PBS_FIFO_D     32
`define PBS_FIFO_AW    5

`endif

// ### pkg/pbs_pkg.sv
// Types shared by the burst address sequencer
package pbs_pkg;

	// Link phase of the sequencer
	typedef enum logic [1:0]
	{
		PBS_IDLE,
		PBS_CMD,
		PBS_BURST
	} pbs_state_t;

endpackage

// ### core/pbs_fifo.sv
// Word FIFO between the link sequencer and the register bus
`timescale 1ns/1ns
`default_nettype none

module pbs_fifo
	import pbs_pkg::*;
#(
	parameter int W  = 32,
	parameter int D  = 32,
	parameter int AW = 5
)
(
	// Clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// Fill side
	input  wire logic          in_valid,
	output logic               in_ready,
	input  wire logic [W-1:0]  in_data,
	// Drain side
	output logic               out_valid,
	input  wire logic          out_ready,
	output logic      [W-1:0]  out_data,
	// Fill level
	output logic      [AW:0]   level
);

	logic [W-1:0]  mem_ff [D];
	logic [AW-1:0] wptr_ff;
	logic [AW-1:0] rptr_ff;
	logic [AW:0]   cnt_ff;
	logic          push;
	logic          pop;

	// Full and empty come straight from the count
	assign in_ready  = (cnt_ff != (AW+1)'(D));
	assign out_valid = (cnt_ff != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem_ff[rptr_ff];
	assign level     = cnt_ff;

	// Storage, written by index
	always_ff @(posedge pclk)
	begin
		if (push)
			mem_ff[wptr_ff] <= in_data;
	end

	// Pointers and count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			cnt_ff  <= '0;
		end
		else
		begin
			if (push)
				wptr_ff <= wptr_ff + 1'b1;
			if (pop)
				rptr_ff <= rptr_ff + 1'b1;
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule // pbs_fifo

`default_nettype wire

// ### core/pbs_seq.sv
// Burst address sequencer: link capture, wrap logic, APB registers
`timescale 1ns/1ns
`default_nettype none
`include "pbs_consts.svh"

module pbs_seq
	import pbs_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	// Link pins, asynchronous to pclk
	input  wire logic        link_ck,
	input  wire logic        cs_n,
	input  wire logic [7:0]  dq_in
);

	// ----------------------------------------
	// Link input synchronisers
	// ----------------------------------------
	logic [9:0] sync1_ff;
	logic [9:0] sync2_ff;
	logic       ck_q_ff;
	logic       cs_q_ff;
	logic       ck_s;
	logic       cs_n_s;
	logic [7:0] dq_s;
	logic       ck_edge;
	logic       ck_rise;
	logic       cs_fall;

	// Two stages; the first is read by the second only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_ff <= 10'h200;
			sync2_ff <= 10'h200;
		end
		else
		begin
			sync1_ff <= {cs_n, link_ck, dq_in};
			sync2_ff <= sync1_ff;
		end
	end

	assign cs_n_s = sync2_ff[9];
	assign ck_s   = sync2_ff[8];
	assign dq_s   = sync2_ff[7:0];

	// Edge finders look at the synchronised copy
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ck_q_ff <= 1'b0;
			cs_q_ff <= 1'b1;
		end
		else
		begin
			ck_q_ff <= ck_s;
			cs_q_ff <= cs_n_s;
		end
	end

	assign ck_edge = (ck_s != ck_q_ff);
	assign ck_rise = ck_s & ~ck_q_ff;
	assign cs_fall = cs_q_ff & ~cs_n_s;

	// ----------------------------------------
	// Configuration register
	// ----------------------------------------
	logic [2:0]  cfg_ff;
	logic        cfg_wr_ff;
	logic        ovr_ff;
	logic [31:0] start_ff;
	logic        wr_acc;
	logic        rd_setup;
	logic        pop_acc;

	assign wr_acc = psel & penable & pwrite;

	// Reset to legacy wrap of 32 bytes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_ff    <= `PBS_CFG_RST;
			cfg_wr_ff <= 1'b0;
		end
		else if (wr_acc && paddr == `PBS_CFG_OFS)
		begin
			cfg_ff    <= pwdata[2:0];
			cfg_wr_ff <= 1'b1;
		end
	end

	// ----------------------------------------
	// Burst sequencer
	// ----------------------------------------
	pbs_state_t  st_ff;
	logic [47:0] ca_ff;
	logic [2:0]  nbyte_ff;
	logic [31:0] addr_ff;
	logic [5:0]  mask_ff;
	logic [5:0]  cnt_ff;
	logic        lin_ff;
	logic        hyb_ff;
	logic [31:0] nxt_addr;
	logic        nxt_lin;
	logic [31:0] mask32;
	logic [47:0] ca_full;
	logic        start;
	logic        word;
	logic        push_rdy;
	logic        push;
	logic [5:0]  dec_mask;
	logic [5:0]  fifo_lvl;
	logic [31:0] fifo_head;
	logic        fifo_valid;

	assign ca_full = {ca_ff[39:0], dq_s};
	assign start   = (st_ff == PBS_CMD) && ck_edge && !cs_n_s && nbyte_ff == `PBS_CA_LAST;
	assign word    = (st_ff == PBS_BURST) && ck_rise && !cs_n_s;
	assign push    = word & push_rdy;
	assign mask32  = {26'h0, mask_ff};

	// Group length decode, in words less one
	always_comb
	begin
		case (cfg_ff[1:0])
			2'h0:    dec_mask = 6'h3F;
			2'h1:    dec_mask = 6'h1F;
			2'h2:    dec_mask = 6'h07;
			default: dec_mask = 6'h0F;
		endcase
	end

	// Next word address for the running burst
	always_comb
	begin
		nxt_addr = addr_ff + 32'h1;
		nxt_lin  = lin_ff;
		if (!lin_ff)
		begin
			if (hyb_ff && cnt_ff == mask_ff)
			begin
				// One full wrap done: first word of the next group
				nxt_addr = (addr_ff | mask32) + 32'h1;
				nxt_lin  = 1'b1;
			end
			else
			begin
				// Only group bits advance, upper bits held
				nxt_addr = (addr_ff & ~mask32) | ((addr_ff + 32'h1) & mask32);
			end
		end
	end

	// Link phase: command bytes, then words until chip select rises
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_ff <= PBS_IDLE;
		else if (cs_n_s)
			st_ff <= PBS_IDLE;
		else
		begin
			case (st_ff)
				PBS_IDLE:
					if (cs_fall)
						st_ff <= PBS_CMD;
				PBS_CMD:
					if (start)
						st_ff <= PBS_BURST;
				PBS_BURST:
					st_ff <= PBS_BURST;
				default:
					st_ff <= PBS_IDLE;
			endcase
		end
	end

	// Command-address capture, one byte per link edge, high byte first
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ca_ff    <= 48'h0;
			nbyte_ff <= 3'h0;
		end
		else if (st_ff != PBS_CMD)
			nbyte_ff <= 3'h0;
		else if (ck_edge)
		begin
			ca_ff    <= ca_full;
			nbyte_ff <= nbyte_ff + 3'h1;
		end
	end

	// Burst mode latched once per burst; config edits wait for the next
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mask_ff  <= 6'h0F;
			hyb_ff   <= 1'b0;
			lin_ff   <= 1'b1;
			start_ff <= 32'h0;
		end
		else if (start)
		begin
			mask_ff  <= dec_mask;
			hyb_ff   <= ~cfg_ff[`PBS_HYB_BIT];
			lin_ff   <= ca_full[`PBS_BT_BIT];
			start_ff <= {ca_full[44:16], ca_full[2:0]};
		end
		else if (push)
			lin_ff <= nxt_lin;
	end

	// Word address and words-in-burst count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_ff <= 32'h0;
			cnt_ff  <= 6'h0;
		end
		else if (start)
		begin
			addr_ff <= {ca_full[44:16], ca_full[2:0]};
			cnt_ff  <= 6'h0;
		end
		else if (push)
		begin
			addr_ff <= nxt_addr;
			cnt_ff  <= cnt_ff + 6'h1;
		end
	end

	// Full FIFO stalls the sequencer; lost word is flagged, set beats clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ovr_ff <= 1'b0;
		else if (word && !push_rdy)
			ovr_ff <= 1'b1;
		else if (wr_acc && paddr == `PBS_STAT_OFS && pwdata[`PBS_ST_OVR])
			ovr_ff <= 1'b0;
	end

	// ----------------------------------------
	// Address FIFO
	// ----------------------------------------
	pbs_fifo #(
		.W  (`PBS_FIFO_W),
		.D  (`PBS_FIFO_D),
		.AW (`PBS_FIFO_AW)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (word),
		.in_ready  (push_rdy),
		.in_data   (addr_ff),
		.out_valid (fifo_valid),
		.out_ready (pop_acc),
		.out_data  (fifo_head),
		.level     (fifo_lvl)
	);

	// ----------------------------------------
	// APB read path
	// ----------------------------------------
	logic [31:0] rdata_ff;
	logic        err_ff;

	assign rd_setup = psel & ~penable;
	assign pop_acc  = psel & penable & ~pwrite & (paddr == `PBS_ADDR_OFS) & ~err_ff;
	assign pready   = 1'b1;
	assign prdata   = rdata_ff;
	assign pslverr  = psel & penable & err_ff;

	// Read data and error are formed in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdata_ff <= 32'h0;
			err_ff   <= 1'b0;
		end
		else if (rd_setup)
		begin
			rdata_ff <= 32'h0;
			err_ff   <= 1'b0;
			case (paddr)
				`PBS_CFG_OFS:
					rdata_ff <= {29'h0, cfg_ff};
				`PBS_STAT_OFS:
					rdata_ff <= {18'h0, fifo_lvl, 5'h0, ovr_ff,
						lin_ff, (st_ff != PBS_IDLE)};
				`PBS_ADDR_OFS:
				begin
					// Empty FIFO answers with an error, nothing popped
					rdata_ff <= fifo_valid ? fifo_head : 32'h0;
					err_ff   <= ~fifo_valid | pwrite;
				end
				`PBS_START_OFS:
				begin
					rdata_ff <= start_ff;
					err_ff   <= pwrite;
				end
				default:
					err_ff <= 1'b1;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	wrap_confine_a: assert property (
		push && !lin_ff && !(hyb_ff && cnt_ff == mask_ff)
		|=> (addr_ff & ~mask32) == (start_ff & ~mask32))
		else $error("wrapped address left its group");

	group_size_a: assert property (
		st_ff == PBS_BURST |-> mask_ff inside {6'h07, 6'h0F, 6'h1F, 6'h3F})
		else $error("illegal wrap group size");

	wrap_jump_a: assert property (
		push && !lin_ff && !hyb_ff && (addr_ff & mask32) == mask32
		|=> (addr_ff & mask32) == 32'h0)
		else $error("wrap did not return to group start");

	hybrid_next_a: assert property (
		push && !lin_ff && hyb_ff && cnt_ff == mask_ff
		|=> lin_ff && addr_ff == ($past(addr_ff) | mask32) + 32'h1)
		else $error("hybrid did not move to next group");

	linear_inc_a: assert property (
		push && lin_ff |=> lin_ff && addr_ff == $past(addr_ff) + 32'h1)
		else $error("linear burst did not increment");

	mode_sel_a: assert property (
		start |=> hyb_ff == !$past(cfg_ff[2]) && lin_ff == $past(ca_full[45]))
		else $error("burst mode latched wrongly");

	len_decode_a: assert property (
		start && cfg_ff[1:0] == 2'h2 |=> mask_ff == 6'h07)
		else $error("16 byte length decoded wrongly");

	cfg_reset_a: assert property (
		!cfg_wr_ff |-> cfg_ff == 3'h7)
		else $error("config not at reset value");

	upper_hold_a: assert property (
		push && !lin_ff && !hyb_ff |=> addr_ff[31:6] == $past(addr_ff[31:6]))
		else $error("upper word bits moved during wrap");

	hyb_done_c: cover property (push && hyb_ff && cnt_ff == mask_ff);
	legacy_c:   cover property (push && !hyb_ff && !lin_ff && (addr_ff & mask32) == mask32);
	overrun_c:  cover property (word && !push_rdy);

endmodule // pbs_seq

`default_nettype wire

// ### dv/pbs_host_model.sv
// Host controller model driving link clock, chip select and command bytes
`timescale 1ns/1ns
`default_nettype none

module pbs_host_model
(
	// Link pins toward the sequencer
	output logic       link_ck,
	output logic       cs_n,
	output logic [7:0] dq_in
);
	// Idle: clock still, not selected
	initial
	begin
		link_ck = 1'b0;
		cs_n = 1'b1;
		dq_in = 8'hA5;
	end

	// One burst: six bytes on both edges, then one rising edge per word.
	// Latency settings are not modelled, the link runs slow
	task automatic run_burst(input logic [47:0] ca, input int n);
		#37 cs_n = 1'b0;
		for (int i = 5; i >= 0; i--)
		begin
			dq_in = ca[8*i +: 8];
			#200 link_ck = ~link_ck;
			#200;
		end
		// Released data lines flip every word, so every second word shows the last byte again
		for (int i = 0; i < n; i++)
		begin
			dq_in = ~dq_in;
			#400 link_ck = 1'b1;
			#400 link_ck = 1'b0;
		end
		#400 cs_n = 1'b1; // Host always ends the burst
		dq_in = ~dq_in;
	endtask
endmodule // pbs_host_model

`default_nettype wire

// ### dv/psram_burst_address_sequencer_test.sv
// Testbench: APB register tests and link bursts for the sequencer
`timescale 1ns/1ns
`default_nettype none
`include "pbs_consts.svh"

module psram_burst_address_sequencer_test;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        link_ck;
	logic        cs_n;
	logic [7:0]  dq_in;
	logic [31:0] q;
	logic        e;
	logic [31:0] gws [4] = '{32'h40, 32'h20, 32'h08, 32'h10};
	int          errors = 0;
	int          n_compared = 0;
	int          cycles = 0;

	pbs_seq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .link_ck(link_ck), .cs_n(cs_n), .dq_in(dq_in));
	pbs_host_model host (.link_ck(link_ck), .cs_n(cs_n), .dq_in(dq_in));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic give_verdict();
		$display("counts: %0d compared, %0d errors", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; held until pready is seen high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// No local limit: a slave that never answers is caught by the watchdog
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Expected word address k of a burst
	function automatic logic [31:0] exp_addr(input logic [2:0] sel, input logic lin,
		input logic [31:0] st, input int k);
		logic [31:0] gw;
		logic [31:0] base;
		gw = gws[sel[1:0]];
		base = st & ~(gw - 1);
		if (lin)
			return st + k;
		if (sel[2] || k < gw)
			return base | ((st + k) & (gw - 1));
		return base + k;
	endfunction

	// Run a burst, then drain and compare every address
	task automatic burst_test(input logic [2:0] sel, input logic lin, input logic [31:0] st);
		xfer(1'b1, `PBS_CFG_OFS, {29'h0, sel});
		xfer(1'b0, `PBS_CFG_OFS, 32'h0);
		chk(q, {29'h0, sel});
		host.run_burst({2'b10, lin, st[31:3], 13'h0, st[2:0]}, 24);
		repeat (8) @(posedge pclk);
		for (int k = 0; k < 24; k++)
		begin
			xfer(1'b0, `PBS_ADDR_OFS, 32'h0);
			chk(q, exp_addr(sel, lin, st, k));
		end
		xfer(1'b0, `PBS_START_OFS, 32'h0);
		chk(q, st);
		xfer(1'b0, `PBS_ADDR_OFS, 32'h0);
		chk({31'h0, e}, 32'h1);
		$display("burst test sel %0d linear %0d done", sel, lin);
	endtask

	// ----------------------------------------
	// Clock, reset, watchdog
	// ----------------------------------------
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// Generous ceiling: all bursts need well under half of it
	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			errors++;
			give_verdict();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, `PBS_CFG_OFS, 32'h0);
		chk(q, 32'h7);
		chk({31'h0, e}, 32'h0);
		xfer(1'b0, `PBS_STAT_OFS, 32'h0);
		chk(q, 32'h2);
		xfer(1'b0, 8'h10, 32'h0);
		chk({31'h0, e}, 32'h1);
		xfer(1'b1, `PBS_START_OFS, 32'h5);
		chk({31'h0, e}, 32'h1);
		$display("reset test done");
		for (int s = 0; s < 8; s++)
			burst_test(s[2:0], 1'b0, 32'h0012_3400 + gws[s[1:0]] - 4);
		burst_test(3'h0, 1'b1, 32'h0012_33FE);
		burst_test(3'h6, 1'b1, 32'h0012_33FE);
		// Overrun: 34 words into 32 entries, nobody draining
		fork
			host.run_burst({2'b10, 1'b1, 29'h0, 13'h0, 3'h0}, 34);
			begin
				repeat (60) @(posedge pclk);
				xfer(1'b0, `PBS_STAT_OFS, 32'h0);
				chk(q & 32'h3, 32'h3);
			end
		join
		repeat (8) @(posedge pclk);
		xfer(1'b0, `PBS_STAT_OFS, 32'h0);
		chk(q & 32'h3F07, 32'h2006);
		for (int k = 0; k < 32; k++)
		begin
			xfer(1'b0, `PBS_ADDR_OFS, 32'h0);
			chk(q, k);
		end
		xfer(1'b1, `PBS_STAT_OFS, 32'h4);
		xfer(1'b0, `PBS_STAT_OFS, 32'h0);
		chk(q, 32'h2);
		$display("overrun test done");
		give_verdict();
	end
endmodule // psram_burst_address_sequencer_test

`default_nettype wire
